// [rtl/twi_port.sv]
// two-wire serial port, bus master or addressed slave, behind an apb slave
`include "twi_port_cfg.svh"
`default_nettype none
// How it works
// RL1: control regs read/write, status low six read-only
// RL2: address reg is own address or baud reload
// RL3: full received byte moves to buffer, flag set
// RL4: buffer write loads buffer and shift register
// RL5: status bit 7 selects slew control
// RL6: status bit 6 selects smbus input thresholds
// RL7: status bit 5 flags data versus address
// RL8: bits 4,3 flag last stop or start
// RL9: bit 2 slave direction or master transmitting
// RL10: direction or sequence enables means busy
// RL11: bit 1 asks software to rewrite address
// RL12: bit 0 shows buffer full
// RL13: master makes clocks, start, stop, repeated start
// RL14: first byte is address plus direction bit
// RL15: eight bits then acknowledge each byte
// RL16: baud generator sets bus clock rate
// RL17: start enable makes start, then flag
// RL18: byte out, ack captured, flag after ninth
// RL19: stop enable makes stop, then flag
// RL20: start and stop detected, flag raised
// RL21: 7-bit, 10-bit and general call addressing
// RL22: lines only pulled low or released
module twi_port
  import twi_port_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe,
  output logic sda_o,
  output logic sda_oe,
  output logic slew_ctrl_off,
  output logic smbus_levels,
  output logic port_busy
);

  state_t q;
  state_t n;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic en;
  logic master;
  logic ten_bit;
  logic tick;
  logic setup;
  logic access;
  logic hit7;
  logic hit_gc;
  logic hit_hi;
  logic hit_lo;
  logic [7:0] rd_byte;
  logic [7:0] status;

  // ***************************************************
  // line conditioning and decode
  // ***************************************************
  // edges are taken from the second sync stage and its delayed copy only
  assign scl = q.scl_sy[1];
  assign sda = q.sda_sy[1];
  assign scl_rise = scl & ~q.scl_d;
  assign scl_fall = ~scl & q.scl_d;
  assign start_det = scl & q.scl_d & q.sda_d & ~sda; // RL20
  assign stop_det = scl & q.scl_d & ~q.sda_d & sda; // RL20
  assign en = q.control_reg_one[`C1_ENABLE];
  assign master = q.control_reg_one[3:0] == `MODE_MASTER;
  assign ten_bit = q.control_reg_one[3:0] == `MODE_SLAVE10;
  assign tick = q.brg == 7'h00; // RL16
  assign setup = psel & ~penable;
  assign access = psel & penable & q.rdy;

  // address compare for the byte just shifted in
  assign hit7 = q.shift_reg[7:1] == q.address_baud_reg[7:1]; // RL2
  assign hit_gc = q.shift_reg == `GCALL_ADDR & q.control_reg_two[`C2_GCALL]; // RL21
  assign hit_hi = q.shift_reg[7:3] == `TEN_BIT_HI
    & q.shift_reg[2:1] == q.address_baud_reg[2:1]; // RL21
  assign hit_lo = q.shift_reg == q.address_baud_reg; // RL21

  // status byte as software sees it
  assign status = {q.slew_control_bit, q.smbus_sel, q.data_not_addr, q.stop_seen,
    q.start_seen, q.rw_info, q.address_update_needed, q.buffer_full};

  // read mux, sampled in the setup cycle
  always_comb begin
    rd_byte = 8'h00;
    case (paddr)
      `OFS_CTL1: rd_byte = q.control_reg_one;
      `OFS_CTL2: rd_byte = q.control_reg_two;
      `OFS_STAT: rd_byte = status;
      `OFS_XBUF: rd_byte = q.transfer_buffer;
      `OFS_ADBR: rd_byte = q.address_baud_reg;
      `OFS_EVT: rd_byte = {7'h00, q.serial_event_flag};
      default: rd_byte = 8'h00;
    endcase
  end

  // ***************************************************
  // next state
  // ***************************************************
  always_comb begin
    n = q;
    n.scl_sy = {q.scl_sy[0], scl_i};
    n.sda_sy = {q.sda_sy[0], sda_i};
    n.scl_d = scl;
    n.sda_d = sda;
    n.drv.scl_o = 1'b0; // RL22
    n.drv.sda_o = 1'b0; // RL22

    // apb: answer one cycle after setup, software clears come before hardware sets
    n.rdy = 1'b0;
    n.err = 1'b0;
    if (setup) begin
      n.rdy = 1'b1;
      n.rdata = {24'h000000, rd_byte};
      n.err = rd_byte == 8'h00 & paddr != `OFS_CTL1 & paddr != `OFS_CTL2
        & paddr != `OFS_STAT & paddr != `OFS_XBUF & paddr != `OFS_ADBR
        & paddr != `OFS_EVT;
    end
    if (access & pwrite & ~q.err) begin
      case (paddr)
        `OFS_CTL1: n.control_reg_one = pwdata[7:0]; // RL1
        `OFS_CTL2: n.control_reg_two = pwdata[7:0]; // RL1
        `OFS_STAT: begin
          n.slew_control_bit = pwdata[7]; // RL5
          n.smbus_sel = pwdata[6]; // RL6
        end
        `OFS_XBUF: begin
          n.transfer_buffer = pwdata[7:0]; // RL4
          n.shift_reg = pwdata[7:0]; // RL4
          n.buffer_full = 1'b1; // RL12
          if (master & en & q.ms == M_IDLE) begin
            n.mop = OP_TX; // RL18
            n.bc = 4'h0;
            n.rw_info = 1'b1; // RL9
            n.ms = M_DAT;
          end
        end
        `OFS_ADBR: begin
          n.address_baud_reg = pwdata[7:0]; // RL2
          n.address_update_needed = 1'b0; // RL11
        end
        `OFS_EVT: if (pwdata[0]) n.serial_event_flag = 1'b0;
        default: n.address_baud_reg = q.address_baud_reg;
      endcase
    end
    // reading the buffer empties it
    if (access & ~pwrite & paddr == `OFS_XBUF) n.buffer_full = 1'b0; // RL12

    // bus condition monitor, used in both roles
    if (start_det) begin
      n.start_seen = 1'b1; // RL8
      n.stop_seen = 1'b0;
      n.serial_event_flag = 1'b1; // RL20
      n.sl_on = ~master;
      n.sl_adr = 1'b1;
      n.sl_hi = 1'b0;
      n.sl_tx = 1'b0;
      n.sc = `SC_START; // the clock fall right after a start carries no bit
      if (~master) n.rw_info = 1'b0; // RL9
    end
    if (stop_det) begin
      n.stop_seen = 1'b1; // RL8
      n.start_seen = 1'b0;
      n.serial_event_flag = 1'b1; // RL20
      n.sl_on = 1'b0;
      if (~master) n.rw_info = 1'b0; // RL9
    end

    // baud generator: each sequencer step lasts reload plus one cycles, and the clock low phase takes two steps
    if (q.ms == M_IDLE | tick) n.brg = q.address_baud_reg[6:0]; // RL2
    else n.brg = q.brg - 7'h01; // RL16

    // ***************************************************
    // master sequencer
    // ***************************************************
    if (en & master) begin
      case (q.ms)
        M_IDLE: begin
          if (q.control_reg_two[`C2_START]) begin
            n.drv.sda_oe = 1'b0; // RL17
            n.drv.scl_oe = 1'b0;
            n.ms = M_ST1;
          end else if (q.control_reg_two[`C2_RSTART]) begin
            n.drv.sda_oe = 1'b0; // RL13
            n.ms = M_RS1;
          end else if (q.control_reg_two[`C2_STOP]) begin
            n.drv.sda_oe = 1'b1; // RL19
            n.ms = M_SP1;
          end else if (q.control_reg_two[`C2_RECV]) begin
            n.mop = OP_RX; // RL15
            n.bc = 4'h0;
            n.ms = M_DAT;
          end else if (q.control_reg_two[`C2_ACKSEQ]) begin
            n.mop = OP_ACK; // RL15
            n.bc = `ACK_SLOT;
            n.ms = M_DAT;
          end
        end
        // repeated start: release data with clock low, then clock high
        M_RS1: if (tick) begin
          n.drv.scl_oe = 1'b0; // RL13
          n.ms = M_ST1;
        end
        // start: data falls while clock is high, after one baud step of setup
        M_ST1: if (tick & scl) begin
          n.drv.sda_oe = 1'b1; // RL13
          n.ms = M_ST2;
        end
        M_ST2: if (tick) begin
          n.drv.scl_oe = 1'b1; // RL13
          n.control_reg_two[`C2_START] = 1'b0; // RL17
          n.control_reg_two[`C2_RSTART] = 1'b0;
          n.serial_event_flag = 1'b1; // RL17
          n.ms = M_IDLE;
        end
        // put the next bit on the data line while the clock is low
        M_DAT: if (tick) begin
          case (q.mop)
            OP_TX: n.drv.sda_oe = q.bc != `ACK_SLOT & ~q.shift_reg[7]; // RL14
            OP_ACK: n.drv.sda_oe = ~q.control_reg_two[`C2_ACKDATA]; // RL15
            default: n.drv.sda_oe = 1'b0;
          endcase
          n.ms = M_LOW;
        end
        M_LOW: if (tick) begin
          n.drv.scl_oe = 1'b0; // RL13
          n.ms = M_HIGH;
        end
        // counting waits for the clock to be seen high, so a slave may stretch it
        M_HIGH: if (tick & scl) begin
          n.drv.scl_oe = 1'b1; // RL13
          n.bc = q.bc + 4'h1;
          n.ms = M_DAT;
          if (q.mop == OP_TX & q.bc != `ACK_SLOT) n.shift_reg = {q.shift_reg[6:0], 1'b0};
          if (q.mop == OP_RX) n.shift_reg = {q.shift_reg[6:0], sda}; // RL15
          if (q.mop == OP_TX & q.bc == `LAST_DATA_BIT) n.buffer_full = 1'b0; // RL12
          if (q.mop == OP_TX & q.bc == `ACK_SLOT) begin
            n.control_reg_two[`C2_ACKSTAT] = sda; // RL18
            n.rw_info = 1'b0; // RL9
            n.serial_event_flag = 1'b1; // RL18
            n.drv.sda_oe = 1'b0;
            n.ms = M_IDLE;
          end
          if (q.mop == OP_RX & q.bc == `LAST_DATA_BIT) begin
            n.transfer_buffer = {q.shift_reg[6:0], sda}; // RL3
            n.buffer_full = 1'b1; // RL3
            n.serial_event_flag = 1'b1; // RL3
            n.control_reg_two[`C2_RECV] = 1'b0;
            n.ms = M_IDLE;
          end
          if (q.mop == OP_ACK) begin
            n.control_reg_two[`C2_ACKSEQ] = 1'b0; // RL15
            n.serial_event_flag = 1'b1;
            n.drv.sda_oe = 1'b0;
            n.ms = M_IDLE;
          end
        end
        // stop: data low, clock up, then data released while clock is high
        M_SP1: if (tick) begin
          n.drv.scl_oe = 1'b0; // RL13
          n.ms = M_SP2;
        end
        M_SP2: if (tick & scl) begin
          n.drv.sda_oe = 1'b0; // RL19
          n.ms = M_SP3;
        end
        M_SP3: if (tick) begin
          n.control_reg_two[`C2_STOP] = 1'b0; // RL19
          n.serial_event_flag = 1'b1; // RL19
          n.ms = M_IDLE;
        end
        default: n.ms = M_IDLE;
      endcase
    end

    // ***************************************************
    // slave engine
    // ***************************************************
    // no clock stretching: a read must have its byte loaded before the ack ends
    if (en & ~master & q.sl_on) begin
      if (scl_rise) begin
        if (~q.sl_tx & q.sc != `ACK_SLOT) n.shift_reg = {q.shift_reg[6:0], sda};
        if (q.sl_tx & q.sc == `ACK_SLOT & sda) begin
          n.sl_on = 1'b0; // master refused, drop the read
          n.rw_info = 1'b0; // RL9
        end
      end
      if (scl_fall) begin
        if (q.sc == `ACK_SLOT) begin
          n.sc = 4'h0;
          n.drv.sda_oe = q.sl_tx & ~q.shift_reg[7]; // RL22
          if (q.sl_tx) n.data_not_addr = 1'b1; // RL7
          if (q.sl_tx) n.serial_event_flag = 1'b1;
        end else if (q.sc == `LAST_DATA_BIT) begin
          n.sc = `ACK_SLOT;
          n.drv.sda_oe = 1'b0;
          if (q.sl_tx) n.buffer_full = 1'b0; // RL12
          else if (q.sl_adr) begin
            if (ten_bit & ~q.sl_hi & hit_hi) begin
              n.sl_hi = 1'b1; // RL21
              n.address_update_needed = 1'b1; // RL11
              n.rw_info = q.shift_reg[0];
              n.sl_tx = q.shift_reg[0] & q.start_seen & q.data_not_addr;
              n.sl_adr = ~(q.shift_reg[0] & q.data_not_addr);
              n.drv.sda_oe = 1'b1;
              n.data_not_addr = 1'b0; // RL7
            end else if ((ten_bit & q.sl_hi & hit_lo) | (~ten_bit & hit7) | hit_gc) begin
              if (ten_bit) n.address_update_needed = 1'b1; // RL11
              n.sl_adr = 1'b0;
              n.rw_info = ~ten_bit & q.shift_reg[0]; // RL9
              n.sl_tx = ~ten_bit & ~hit_gc & q.shift_reg[0];
              n.drv.sda_oe = 1'b1;
              n.data_not_addr = 1'b0; // RL7
              n.transfer_buffer = q.shift_reg; // RL3
              n.buffer_full = 1'b1;
              n.serial_event_flag = 1'b1;
            end else begin
              n.sl_on = 1'b0;
            end
          end else begin
            n.transfer_buffer = q.shift_reg; // RL3
            n.buffer_full = 1'b1; // RL3
            n.serial_event_flag = 1'b1; // RL3
            n.data_not_addr = 1'b1; // RL7
            n.drv.sda_oe = 1'b1;
          end
        end else begin
          n.sc = q.sc + 4'h1;
          if (q.sl_tx) begin
            n.drv.sda_oe = ~q.shift_reg[6]; // RL22
            n.shift_reg = {q.shift_reg[6:0], 1'b0};
          end
        end
      end
    end
    if (en & ~master & ~n.sl_on & q.sl_on) n.drv.sda_oe = 1'b0;

    // a disabled port lets go of the bus and forgets conditions
    if (~en) begin
      n.start_seen = 1'b0; // RL8
      n.stop_seen = 1'b0; // RL8
      n.ms = M_IDLE;
      n.sl_on = 1'b0;
      n.drv.scl_oe = 1'b0; // RL22
      n.drv.sda_oe = 1'b0; // RL22
    end

    // busy is direction or any sequence request still pending
    n.busy = n.rw_info | n.control_reg_two[`C2_START] | n.control_reg_two[`C2_RSTART]
      | n.control_reg_two[`C2_STOP] | n.control_reg_two[`C2_RECV]
      | n.control_reg_two[`C2_ACKSEQ]; // RL10
  end

  // ***************************************************
  // state register
  // ***************************************************
  // every field resets to zero, so a plain constant is enough
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // outputs come straight from the state register
  assign prdata = q.rdata;
  assign pready = q.rdy;
  assign pslverr = q.err;
  assign scl_o = q.drv.scl_o;
  assign scl_oe = q.drv.scl_oe;
  assign sda_o = q.drv.sda_o;
  assign sda_oe = q.drv.sda_oe;
  assign slew_ctrl_off = q.slew_control_bit; // RL5
  assign smbus_levels = q.smbus_sel; // RL6
  assign port_busy = q.busy; // RL10

endmodule // twi_port
`default_nettype wire

// [rtl/twi_port_cfg.svh]
// constants for the two-wire serial port: offsets, bit positions, codes
`ifndef TWI_PORT_CFG_SVH
`define TWI_PORT_CFG_SVH
// ***************************************************
// register byte offsets
// ***************************************************
`define OFS_CTL1 8'h00
`define OFS_CTL2 8'h04
`define OFS_STAT 8'h08
`define OFS_XBUF 8'h0c
`define OFS_ADBR 8'h10
`define OFS_EVT 8'h14
// ***************************************************
// control_reg_one fields
// ***************************************************
`define C1_ENABLE 5
`define MODE_MASTER 4'h8
`define MODE_SLAVE7 4'h6
`define MODE_SLAVE10 4'h7
// ***************************************************
// control_reg_two fields
// ***************************************************
`define C2_START 0
`define C2_RSTART 1
`define C2_STOP 2
`define C2_RECV 3
`define C2_ACKSEQ 4
`define C2_ACKDATA 5
`define C2_ACKSTAT 6
`define C2_GCALL 7
// ***************************************************
// addresses and bit counts
// ***************************************************
`define GCALL_ADDR 8'h00
`define TEN_BIT_HI 5'h1e
`define LAST_DATA_BIT 4'h7
`define ACK_SLOT 4'h8
`define SC_START 4'hf
`define CTL_RST 8'h00
`endif

// [rtl/twi_port_pkg.sv]
// types shared by the two-wire serial port
`default_nettype none
package twi_port_pkg;
  // master sequencer states
  typedef enum logic [3:0] {
    M_IDLE, M_ST1, M_ST2, M_RS1, M_DAT, M_LOW, M_HIGH, M_SP1, M_SP2, M_SP3
  } msm_t;
  // kind of master byte operation
  typedef enum logic [1:0] {OP_TX, OP_RX, OP_ACK} mop_t;
  // open-drain drive of both lines
  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } line_drv_t;
  // whole state of the port
  typedef struct packed {
    logic [7:0] control_reg_one;
    logic [7:0] control_reg_two;
    logic slew_control_bit;
    logic smbus_sel;
    logic data_not_addr;
    logic stop_seen;
    logic start_seen;
    logic rw_info;
    logic address_update_needed;
    logic buffer_full;
    logic [7:0] transfer_buffer;
    logic [7:0] shift_reg;
    logic [7:0] address_baud_reg;
    logic serial_event_flag;
    logic busy;
    msm_t ms;
    mop_t mop;
    logic [6:0] brg;
    logic [3:0] bc;
    line_drv_t drv;
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic scl_d;
    logic sda_d;
    logic sl_on;
    logic sl_adr;
    logic sl_tx;
    logic sl_hi;
    logic [3:0] sc;
    logic [31:0] rdata;
    logic rdy;
    logic err;
  } state_t;
endpackage
`default_nettype wire

// [tb/twi_port_properties.sv]
// checker of the two-wire port: apb answers, status mirrors, line sequences
`include "twi_port_cfg.svh"
`default_nettype none
module twi_port_properties #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic slew_ctrl_off,
  input wire logic smbus_levels,
  input wire logic port_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ***
  // access decode
  // ***
  wire setup = psel & ~penable;
  wire wr = psel & penable & pready & pwrite;
  wire stat_wr = wr && paddr == `OFS_STAT;
  wire ctl2_wr = wr && paddr == `OFS_CTL2;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ***
  // properties
  // ***
  // the mirrors are registered twice at most, so two cycles covers either reading
  a_ready_once: assert property (setup |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  a_unmapped_err: assert property (setup && paddr > 8'h14 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_slew_copy: assert property (stat_wr |-> ##2 slew_ctrl_off == $past(pwdata[7], 2))
    else $error("slew output does not follow status");
  a_smbus_copy: assert property (stat_wr |-> ##2 smbus_levels == $past(pwdata[6], 2))
    else $error("smbus output does not follow status");
  a_open_drain: assert property (!scl_o && !sda_o)
    else $error("line driven high");
  a_busy_seq: assert property (ctl2_wr && pwdata[4:0] != 5'h0 |-> ##2 port_busy)
    else $error("busy missing during sequence");
  a_start_make: assert property (ctl2_wr && pwdata[1:0] != 2'h0 |->
    ##[1:1000] $rose(sda_oe) && !scl_oe)
    else $error("no start condition made");
  a_stop_make: assert property (ctl2_wr && pwdata[2] |->
    ##[1:1000] $fell(sda_oe) && !scl_oe)
    else $error("no stop condition made");
  c_start: cover property ($rose(sda_oe) && !scl_oe);
  c_stop: cover property ($fell(sda_oe) && !scl_oe);
  c_refused: cover property (pslverr);
endmodule // twi_port_properties
bind twi_port twi_port_properties #(.ADDR_W(ADDR_W)) props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .scl_i, .sda_i, .scl_o, .scl_oe, .sda_o, .sda_oe, .slew_ctrl_off,
  .smbus_levels, .port_busy
);
`default_nettype wire

// [tb/twi_slave_model.sv]
// behavioural two-wire slave standing on the far side of the port
`default_nettype none
module twi_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a,
  parameter logic [7:0] TXB = 8'h96
) (
  input wire logic pclk,
  input wire logic scl,
  input wire logic sda,
  input wire logic [3:0] stretch,
  output logic scl_oe,
  output logic sda_oe,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sp = 1'b1;
  logic dp = 1'b1;
  logic first = 1'b0;
  logic act = 1'b0;
  logic rd = 1'b0;
  logic [3:0] bc = 4'h0;
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh = 8'h00;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    rx_byte = 8'h00;
  end
  // line edges seen on the pclk grid; lines are only pulled low, release lets the pull-up win
  always @(posedge pclk) begin
    sp <= scl;
    dp <= sda;
    if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else begin
      scl_oe <= 1'b0;
    end
    if (scl && sp && dp && !sda) begin
      bc <= 4'h0;
      first <= 1'b1;
      act <= 1'b0;
      sda_oe <= 1'b0;
    end else if (scl && !sp) begin
      if (bc < 4'h8) begin
        sh <= {sh[6:0], sda};
      end
      if (bc == 4'h8 && rd && sda) begin
        act <= 1'b0; // a refused byte ends the read
      end
      bc <= bc + 4'h1;
    end else if (!scl && sp) begin
      // slow answer: hold the clock low after every fall
      if (stretch != 4'h0) begin
        scl_oe <= 1'b1;
        cnt <= stretch;
      end
      if (bc == 4'h9) begin
        bc <= 4'h0;
        first <= 1'b0;
        sda_oe <= act && rd && !TXB[7];
      end else if (bc == 4'h8 && first) begin
        act <= sh[7:1] == ADDR;
        rd <= sh[0];
        sda_oe <= sh[7:1] == ADDR;
      end else if (bc == 4'h8) begin
        sda_oe <= act && !rd;
        if (act && !rd) begin
          rx_byte <= sh;
        end
      end else begin
        sda_oe <= act && rd && !TXB[3'h7 - bc[2:0]];
      end
    end
  end
endmodule // twi_slave_model
`default_nettype wire

// [tb/tb_top.sv]
// testbench of the two-wire port with a slave model on the lines
`include "twi_port_cfg.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] PEER = 7'h2a;
  localparam logic [7:0] PEER_TX = 8'h96;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic scl_oe;
  logic sda_oe;
  logic slew_ctrl_off;
  logic smbus_levels;
  logic port_busy;
  logic m_scl_oe;
  logic m_sda_oe;
  logic [3:0] stretch = 4'h0;
  logic b_scl_oe = 1'b0;
  logic b_sda_oe = 1'b0;
  logic [7:0] rx_byte;
  logic [31:0] r;
  logic e;
  int errors = 0;
  int checked = 0;
  // open-drain wires with pull-ups: low while any party pulls
  wire scl = ~(scl_oe | m_scl_oe | b_scl_oe);
  wire sda = ~(sda_oe | m_sda_oe | b_sda_oe);
  twi_port #(.ADDR_W(8)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .scl_i(scl), .sda_i(sda), .scl_o(), .scl_oe, .sda_o(), .sda_oe,
    .slew_ctrl_off, .smbus_levels, .port_busy
  );
  twi_slave_model #(.ADDR(PEER), .TXB(PEER_TX)) peer (
    .pclk, .scl, .sda, .stretch, .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .rx_byte
  );
  initial begin
    forever #5 pclk = ~pclk;
  end
  // ***
  // access tasks
  // ***
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // request held until pready is seen at an edge, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) begin
      errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] x, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, r, {24'h0, x});
  endtask
  // poll the event flag under a bound, then clear it
  task automatic wait_evt;
    int n;
    n = 0;
    do begin
      apb(1'b0, `OFS_EVT, 32'h0);
      n++;
    end while (r[0] !== 1'b1 && n < 400);
    chk("event flag", r[0], 1);
    wr(`OFS_EVT, 8'h01);
  endtask
  // bench plays a bus master: data set while the clock is low, 20 cycles per half bit
  task automatic bang(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      b_sda_oe <= ~b[i];
      repeat (20) @(posedge pclk);
      b_scl_oe <= 1'b0;
      repeat (20) @(posedge pclk);
      b_scl_oe <= 1'b1;
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #300000;
    errors++;
    end_of_test;
  end
  // ***
  // scenarios
  // ***
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(`OFS_CTL1, 8'h00, "ctl1 reset");
    rc(`OFS_CTL2, 8'h00, "ctl2 reset");
    rc(`OFS_STAT, 8'h00, "status reset");
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped error", e, 1);
    wr(`OFS_CTL1, 8'h9a);
    rc(`OFS_CTL1, 8'h9a, "ctl1");
    wr(`OFS_CTL2, 8'he0);
    rc(`OFS_CTL2, 8'he0, "ctl2");
    wr(`OFS_CTL2, 8'h00);
    wr(`OFS_STAT, 8'hff);
    rc(`OFS_STAT, 8'hc0, "status");
    chk("slew off", slew_ctrl_off, 1);
    chk("smbus", smbus_levels, 1);
    wr(`OFS_STAT, 8'h00);
    rc(`OFS_STAT, 8'h00, "status");
    chk("slew off", slew_ctrl_off, 0);
    chk("smbus", smbus_levels, 0);
    // port still disabled: buffer write loads the buffer and shift register and sets full, but starts no transfer
    wr(`OFS_XBUF, 8'h3c);
    rc(`OFS_STAT, 8'h01, "full");
    rc(`OFS_XBUF, 8'h3c, "buffer");
    rc(`OFS_STAT, 8'h00, "empty");
    wr(`OFS_ADBR, 8'h04);
    rc(`OFS_ADBR, 8'h04, "baud reload");
    wr(`OFS_CTL1, 8'h28);
    wr(`OFS_CTL2, 8'h01);
    wait_evt;
    rc(`OFS_CTL2, 8'h00, "start clear");
    apb(1'b0, `OFS_STAT, 32'h0);
    chk("start seen", r[4:3], 2'b01);
    wr(`OFS_XBUF, {PEER, 1'b0});
    apb(1'b0, `OFS_STAT, 32'h0);
    chk("transmitting", r[2], 1);
    wait_evt;
    rc(`OFS_CTL2, 8'h00, "address ack");
    wr(`OFS_XBUF, 8'ha5);
    wait_evt;
    chk("peer byte", rx_byte, 8'ha5);
    wr(`OFS_CTL2, 8'h02);
    wait_evt;
    wr(`OFS_XBUF, {~PEER, 1'b0});
    wait_evt;
    apb(1'b0, `OFS_CTL2, 32'h0);
    chk("no ack", r[6], 1);
    // read with a slow peer that stretches every low phase
    stretch <= 4'hf; // longer than the port's own low phase, so the clock is really held
    wr(`OFS_CTL2, 8'h02);
    wait_evt;
    wr(`OFS_XBUF, {PEER, 1'b1});
    wait_evt;
    rc(`OFS_CTL2, 8'h00, "read ack");
    wr(`OFS_CTL2, 8'h08);
    wait_evt;
    apb(1'b0, `OFS_STAT, 32'h0);
    chk("rx full", r[0], 1);
    rc(`OFS_XBUF, PEER_TX, "rx byte");
    wr(`OFS_CTL2, 8'h30);
    wait_evt;
    rc(`OFS_CTL2, 8'h20, "ack seq");
    wr(`OFS_CTL2, 8'h04);
    wait_evt;
    apb(1'b0, `OFS_STAT, 32'h0);
    chk("stop seen", r[4:3], 2'b10);
    wr(`OFS_CTL1, 8'h00);
    apb(1'b0, `OFS_STAT, 32'h0);
    chk("disabled", r[4:3], 2'b00);
    // bench as master, port as 7-bit slave; the peer sees a foreign address and stays quiet
    stretch <= 4'h0;
    wr(`OFS_ADBR, 8'h62);
    wr(`OFS_CTL1, 8'h26);
    b_sda_oe <= 1'b1;
    repeat (20) @(posedge pclk);
    b_scl_oe <= 1'b1;
    bang(8'h62);
    repeat (2) @(posedge pclk);
    b_sda_oe <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("slave ack", sda_oe, 1);
    b_scl_oe <= 1'b0;
    repeat (20) @(posedge pclk);
    b_scl_oe <= 1'b1;
    b_sda_oe <= 1'b1;
    repeat (20) @(posedge pclk);
    b_scl_oe <= 1'b0;
    repeat (20) @(posedge pclk);
    b_sda_oe <= 1'b0;
    repeat (20) @(posedge pclk);
    rc(`OFS_STAT, 8'h11, "slave status");
    rc(`OFS_XBUF, 8'h62, "slave address");
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
